// [rfsd_pkg.sv]
package rfsd_pkg;
	// Register indices (printed offsets are not all multiples of four)
	localparam logic [7:0] IDX_GUARD_WAIT_CONTROL = 8'h31;
	localparam logic [7:0] IDX_GUARD_WAIT_LOW     = 8'h32;
	localparam logic [7:0] IDX_FRAME_CONTROL      = 8'h33;
	localparam logic [7:0] IDX_FRAME_START_DETECT = 8'h34;
	localparam logic [7:0] IDX_RECEIVE_CONTROL    = 8'h35;
	localparam logic [7:0] IDX_IRQ_STATUS         = 8'h40;
	localparam logic [7:0] IDX_IRQ_MASK           = 8'h41;
	localparam logic [7:0] IDX_ENGINE_STATUS      = 8'h42;

	// Reset values
	localparam logic [7:0] RST_GUARD_WAIT_CONTROL = 8'hc0;
	localparam logic [7:0] RST_ZERO               = 8'h00;

	// Guard wait control fields
	localparam int WAIT_ORIGIN_BIT = 7;
	localparam int WAIT_UNIT_BIT   = 6;
	localparam int WAIT_HI_MSB     = 5;
	localparam int WAIT_HI_LSB     = 3;
	localparam int STOP_CODE_MSB   = 2;

	// Frame control fields
	localparam int TX_PARITY_BIT    = 7;
	localparam int RX_PARITY_BIT    = 6;
	localparam int TRAIL_SYM_LSB    = 2;
	localparam int LEAD_SYM_LSB     = 0;
	localparam logic [7:0] FRAME_CONTROL_MASK = 8'hcf;

	// Frame start detect fields
	localparam int SOF_IRQ_EN_BIT    = 5;
	localparam int SOF_SEEN_BIT      = 4;
	localparam int SUBC_IRQ_EN_BIT   = 2;
	localparam int SUBC_SEEN_BIT     = 1;
	localparam int SUBC_NOW_BIT      = 0;
	localparam logic [7:0] FSD_RW_MASK = 8'h24;

	// Receive control fields
	localparam int CONT_RX_BIT = 6;
	localparam int BAUD_MSB    = 2;
	localparam logic [2:0] BAUD_MIN_CODE = 3'h2;

	// Interrupt status bits
	localparam int IRQ_SOF  = 0;
	localparam int IRQ_SUBC = 1;
	localparam int IRQ_WAIT = 2;
	localparam int IRQ_BITS = 3;

	// Carrier unit: 16 periods of 13.56 MHz, in ns, and core cycles
	localparam real CARRIER_UNIT_NS = 16.0 * 1000.0 / 13.56;
	localparam real CORE_PERIOD_NS  = 5.0;
	// Rounded up so the guard wait is never shorter than asked
	localparam int  CARRIER_UNIT_CYC = int'(CARRIER_UNIT_NS / CORE_PERIOD_NS + 0.5);
endpackage : rfsd_pkg

// [rfsd_guard_timer.sv]
`timescale 1ns/1ps
module rfsd_guard_timer #(
	parameter int WAIT_W = 11,
	parameter int TICK_W = 16
) (
	// Clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	// Configuration
	input  wire logic [WAIT_W-1:0] i_wait_value,
	input  wire logic [TICK_W-1:0] i_tick_cycles,
	// Control
	input  wire logic              i_start,
	// Status
	output logic                   o_busy,
	output logic                   o_done
);
	logic [TICK_W-1:0] tick_cnt;
	logic [WAIT_W-1:0] unit_cnt;

	// Counters need these widths to make progress
	if (WAIT_W < 1 || TICK_W < 2) begin : g_bad_widths
		$error("rfsd_guard_timer: bad widths");
	end

	// Restart discards any wait in progress
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_busy   <= 1'b0;
			tick_cnt <= '0;
			unit_cnt <= '0;
		end else if (i_start) begin
			o_busy   <= (i_wait_value != '0);
			tick_cnt <= '0;
			unit_cnt <= i_wait_value;
		end else if (o_busy) begin
			if (tick_cnt + TICK_W'(1) >= i_tick_cycles) begin
				tick_cnt <= '0;
				unit_cnt <= unit_cnt - WAIT_W'(1);
				if (unit_cnt == WAIT_W'(1))
					o_busy <= 1'b0;
			end else begin
				tick_cnt <= tick_cnt + TICK_W'(1);
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			o_done <= 1'b0;
		else
			o_done <= o_busy && !i_start && unit_cnt == WAIT_W'(1)
				&& tick_cnt + TICK_W'(1) >= i_tick_cycles;
	end
endmodule : rfsd_guard_timer

// [rfsd_frame_timing.sv]
`timescale 1ns/1ps
// Summary of operation
// - Wait-origin bit 7: clear starts wait at transmit end, set at receive end.
// - Wait-unit clear: each wait unit is sixteen 13.56 MHz carrier periods.
// - Wait-unit set: each wait unit is half a bit period.
// - Wait value: low register eight bits plus control bits 5..3 as top.
// - No transmit start allowed until guard wait has elapsed.
// - Stop field bits 2..0: none, stop bit, stop plus one to six guard units.
// - Transmit parity enable bit 7 appends parity to each transmitted byte.
// - Receive parity enable bit 6 checks and strips parity before FIFO.
// - Trailing symbol field bits 3..2: none, symbol 0, 1 or 2.
// - Leading symbol field bits 1..0: none, symbol 0, 1 or 2.
// - Start-of-frame enable bit 5 plus detection raises frame-start interrupt.
// - Start-of-frame seen bit 4 sets on detection, held until software clears.
// - Subcarrier enable bit 2 plus detection raises same frame-start interrupt.
// - Subcarrier seen bit 1 sets on detection, held until software clears.
// - Subcarrier now bit 0 shows live detection, unlatched, read only.
// - Receive baud field bits 2..0: codes 2..7 give 26 to 847 kBd.
// - Continuous receive: no auto stop, error byte appended per stream.
module rfsd_frame_timing #(
	parameter int WAIT_W = 11,
	parameter int TICK_W = 16
) (
	// Clock and reset
	input  wire logic              I_CORE_CLK,
	input  wire logic              I_RST,
	// APB slave
	input  wire logic              I_PSEL,
	input  wire logic              I_PENABLE,
	input  wire logic              I_PWRITE,
	input  wire logic [11:0]       I_PADDR,
	input  wire logic [31:0]       I_PWDATA,
	output logic [31:0]            O_PRDATA,
	output logic                   O_PREADY,
	output logic                   O_PSLVERR,
	// Frame engine events (same clock)
	input  wire logic              I_TX_END,
	input  wire logic              I_RX_END,
	input  wire logic              I_TX_REQUEST,
	input  wire logic              I_HALF_BIT_TICK,
	// Detector inputs from the analog side
	input  wire logic              I_SOF_DETECT,
	input  wire logic              I_SUBC_DETECT,
	// Error register copy for continuous receive
	input  wire logic [7:0]        I_ERROR_REG,
	// Configuration to the frame engine
	output logic                   O_TX_START,
	output logic                   O_TX_HOLD,
	output logic [2:0]             O_STOP_AND_GUARD_CODE,
	output logic                   O_STOP_BIT_EN,
	output logic [2:0]             O_EXTRA_GUARD_UNITS,
	output logic                   O_TX_PARITY_EN,
	output logic                   O_RX_PARITY_EN,
	output logic [1:0]             O_TRAILING_SYMBOL,
	output logic [1:0]             O_LEADING_SYMBOL,
	output logic [2:0]             O_RX_BAUD_CODE,
	output logic                   O_RX_BAUD_VALID,
	output logic                   O_CONTINUOUS_RECEIVE,
	output logic                   O_RX_AUTO_STOP,
	output logic                   O_ERROR_BYTE_VALID,
	output logic [7:0]             O_ERROR_BYTE,
	output logic [7:0]             O_RX_CTRL_BITS,
	// Interrupts
	output logic                   O_FRAME_START_INTERRUPT,
	output logic                   O_IRQ
);
	logic [7:0]          guard_wait_control;
	logic [7:0]          guard_wait_low;
	logic [7:0]          frame_control;
	logic [1:0]          fsd_enables;
	logic                sof_seen;
	logic                subc_seen;
	logic [7:0]          receive_control;
	logic [rfsd_pkg::IRQ_BITS-1:0] irq_status;
	logic [rfsd_pkg::IRQ_BITS-1:0] irq_mask;
	logic [2:0]          sof_sync;
	logic [2:0]          subc_sync;
	logic                sof_level;
	logic                subc_level;
	logic                sof_prev;
	logic                subc_prev;
	logic                sof_event;
	logic                subc_event;
	logic [WAIT_W-1:0]   guard_wait_value;
	logic [TICK_W-1:0]   tick_cycles;
	logic                wait_start;
	logic                wait_busy;
	logic                wait_done;
	logic                half_bit_mode;
	logic [7:0]          half_bit_count;
	logic [7:0]          half_bit_run;
	logic                wr_en;
	logic                rd_en;
	logic [9:0]          reg_index;
	logic                addr_ok;
	logic [7:0]          rd_byte;
	logic                hit;

	// Wait value is a fixed eleven-bit concatenation
	if (WAIT_W != 11 || TICK_W < 8) begin : g_bad_widths
		$error("rfsd_frame_timing: unsupported widths");
	end

	// APB: zero wait states, unmapped or misaligned address gives pslverr
	assign reg_index = I_PADDR[11:2];
	assign addr_ok   = (I_PADDR[1:0] == 2'h0) && hit;
	assign wr_en     = I_PSEL && I_PENABLE && I_PWRITE && addr_ok;
	assign rd_en     = I_PSEL && !I_PENABLE && !I_PWRITE;
	assign O_PREADY  = 1'b1;
	assign O_PSLVERR = I_PSEL && I_PENABLE && !addr_ok;

	always_comb begin
		hit     = 1'b1;
		rd_byte = 8'h00;
		unique case (reg_index)
			10'(rfsd_pkg::IDX_GUARD_WAIT_CONTROL): rd_byte = guard_wait_control;
			10'(rfsd_pkg::IDX_GUARD_WAIT_LOW):     rd_byte = guard_wait_low;
			10'(rfsd_pkg::IDX_FRAME_CONTROL):
				rd_byte = frame_control & rfsd_pkg::FRAME_CONTROL_MASK;
			10'(rfsd_pkg::IDX_FRAME_START_DETECT):
				rd_byte = {2'b00, fsd_enables[1], sof_seen, 1'b0, fsd_enables[0],
					subc_seen, subc_level};
			10'(rfsd_pkg::IDX_RECEIVE_CONTROL):    rd_byte = receive_control;
			10'(rfsd_pkg::IDX_IRQ_STATUS):         rd_byte = 8'(irq_status);
			10'(rfsd_pkg::IDX_IRQ_MASK):           rd_byte = 8'(irq_mask);
			10'(rfsd_pkg::IDX_ENGINE_STATUS):
				rd_byte = {6'h00, O_TX_HOLD, wait_busy};
			default: hit = 1'b0;
		endcase
	end

	// Read data sampled in setup, stands through access phase
	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST)
			O_PRDATA <= 32'h00000000;
		else if (rd_en)
			O_PRDATA <= {24'h000000, rd_byte};
	end

	// Plain control registers
	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			guard_wait_control <= rfsd_pkg::RST_GUARD_WAIT_CONTROL;
			guard_wait_low     <= rfsd_pkg::RST_ZERO;
			frame_control      <= rfsd_pkg::RST_ZERO;
			fsd_enables        <= 2'b00;
			receive_control    <= rfsd_pkg::RST_ZERO;
			irq_mask           <= '0;
		end else if (wr_en) begin
			unique case (reg_index)
				10'(rfsd_pkg::IDX_GUARD_WAIT_CONTROL): guard_wait_control <= I_PWDATA[7:0];
				10'(rfsd_pkg::IDX_GUARD_WAIT_LOW):     guard_wait_low <= I_PWDATA[7:0];
				10'(rfsd_pkg::IDX_FRAME_CONTROL):
					frame_control <= I_PWDATA[7:0] & rfsd_pkg::FRAME_CONTROL_MASK;
				10'(rfsd_pkg::IDX_FRAME_START_DETECT):
					fsd_enables <= {I_PWDATA[rfsd_pkg::SOF_IRQ_EN_BIT],
						I_PWDATA[rfsd_pkg::SUBC_IRQ_EN_BIT]};
				10'(rfsd_pkg::IDX_RECEIVE_CONTROL):    receive_control <= I_PWDATA[7:0];
				10'(rfsd_pkg::IDX_IRQ_MASK):
					irq_mask <= I_PWDATA[rfsd_pkg::IRQ_BITS-1:0];
				default: ;
			endcase
		end
	end

	// Detector pins: three stages, change accepted when stages 2 and 3 agree
	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			sof_sync   <= 3'h0;
			subc_sync  <= 3'h0;
			sof_level  <= 1'b0;
			subc_level <= 1'b0;
			sof_prev   <= 1'b0;
			subc_prev  <= 1'b0;
		end else begin
			sof_sync  <= {sof_sync[1:0], I_SOF_DETECT};
			subc_sync <= {subc_sync[1:0], I_SUBC_DETECT};
			if (sof_sync[1] == sof_sync[2])
				sof_level <= sof_sync[2];
			if (subc_sync[1] == subc_sync[2])
				subc_level <= subc_sync[2];
			sof_prev  <= sof_level;
			subc_prev <= subc_level;
		end
	end

	assign sof_event  = sof_level && !sof_prev;
	assign subc_event = subc_level && !subc_prev;

	// Seen flags: write zero clears, detection wins
	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			sof_seen  <= 1'b0;
			subc_seen <= 1'b0;
		end else begin
			if (sof_event)
				sof_seen <= 1'b1;
			else if (wr_en && reg_index == 10'(rfsd_pkg::IDX_FRAME_START_DETECT)
				&& !I_PWDATA[rfsd_pkg::SOF_SEEN_BIT])
				sof_seen <= 1'b0;
			if (subc_event)
				subc_seen <= 1'b1;
			else if (wr_en && reg_index == 10'(rfsd_pkg::IDX_FRAME_START_DETECT)
				&& !I_PWDATA[rfsd_pkg::SUBC_SEEN_BIT])
				subc_seen <= 1'b0;
		end
	end

	assign O_FRAME_START_INTERRUPT = (fsd_enables[1] && sof_seen)
		|| (fsd_enables[0] && subc_seen);

	// Interrupt status: write one clears, new event wins
	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			irq_status <= '0;
		end else begin
			for (int b = 0; b < rfsd_pkg::IRQ_BITS; b++) begin
				if ((b == rfsd_pkg::IRQ_SOF && sof_event && fsd_enables[1])
					|| (b == rfsd_pkg::IRQ_SUBC && subc_event && fsd_enables[0])
					|| (b == rfsd_pkg::IRQ_WAIT && wait_done))
					irq_status[b] <= 1'b1;
				else if (wr_en && reg_index == 10'(rfsd_pkg::IDX_IRQ_STATUS) && I_PWDATA[b])
					irq_status[b] <= 1'b0;
			end
		end
	end

	assign O_IRQ = |(irq_status & irq_mask);

	assign guard_wait_value = {guard_wait_control[rfsd_pkg::WAIT_HI_MSB:rfsd_pkg::WAIT_HI_LSB],
		guard_wait_low};

	assign wait_start = guard_wait_control[rfsd_pkg::WAIT_ORIGIN_BIT] ? I_RX_END : I_TX_END;

	// Half-bit units counted in core cycles from the engine's tick
	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			half_bit_run   <= 8'h00;
			half_bit_count <= 8'h01;
		end else if (I_HALF_BIT_TICK) begin
			half_bit_count <= (half_bit_run == 8'hff) ? 8'hff : half_bit_run + 8'h01;
			half_bit_run   <= 8'h00;
		end else if (half_bit_run != 8'hff) begin
			half_bit_run <= half_bit_run + 8'h01;
		end
	end

	assign half_bit_mode = guard_wait_control[rfsd_pkg::WAIT_UNIT_BIT];
	assign tick_cycles   = half_bit_mode ? TICK_W'(half_bit_count)
		: TICK_W'(rfsd_pkg::CARRIER_UNIT_CYC);

	rfsd_guard_timer #(
		.WAIT_W (WAIT_W),
		.TICK_W (TICK_W)
	) u_guard_timer (
		.i_clk         (I_CORE_CLK),
		.i_rst         (I_RST),
		.i_wait_value  (guard_wait_value),
		.i_tick_cycles (tick_cycles),
		.i_start       (wait_start),
		.o_busy        (wait_busy),
		.o_done        (wait_done)
	);

	assign O_TX_HOLD  = wait_busy || wait_start;
	assign O_TX_START = I_TX_REQUEST && !O_TX_HOLD;

	assign O_STOP_AND_GUARD_CODE = guard_wait_control[rfsd_pkg::STOP_CODE_MSB:0];
	assign O_STOP_BIT_EN         = (O_STOP_AND_GUARD_CODE != 3'h0);
	assign O_EXTRA_GUARD_UNITS   = (O_STOP_AND_GUARD_CODE > 3'h1)
		? O_STOP_AND_GUARD_CODE - 3'h1 : 3'h0;

	assign O_TX_PARITY_EN = frame_control[rfsd_pkg::TX_PARITY_BIT];
	assign O_RX_PARITY_EN = frame_control[rfsd_pkg::RX_PARITY_BIT];
	assign O_TRAILING_SYMBOL = frame_control[rfsd_pkg::TRAIL_SYM_LSB +: 2];
	assign O_LEADING_SYMBOL = frame_control[rfsd_pkg::LEAD_SYM_LSB +: 2];

	assign O_RX_BAUD_CODE  = receive_control[rfsd_pkg::BAUD_MSB:0];
	assign O_RX_BAUD_VALID = (O_RX_BAUD_CODE >= rfsd_pkg::BAUD_MIN_CODE);
	assign O_RX_CTRL_BITS  = receive_control;

	assign O_CONTINUOUS_RECEIVE = receive_control[rfsd_pkg::CONT_RX_BIT];
	assign O_RX_AUTO_STOP       = !O_CONTINUOUS_RECEIVE;

	// Error byte captured at stream end so the FIFO sees a stable copy
	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_ERROR_BYTE_VALID <= 1'b0;
			O_ERROR_BYTE       <= 8'h00;
		end else begin
			O_ERROR_BYTE_VALID <= I_RX_END && O_CONTINUOUS_RECEIVE;
			if (I_RX_END && O_CONTINUOUS_RECEIVE)
				O_ERROR_BYTE <= I_ERROR_REG;
		end
	end
endmodule : rfsd_frame_timing

// [rfsd_frame_timing_properties.sv]
`timescale 1ns/1ps
module rfsd_frame_timing_properties (
	// Clock and reset
	input wire logic       I_CORE_CLK,
	input wire logic       I_RST,
	// APB
	input wire logic       I_PSEL,
	input wire logic       I_PENABLE,
	input wire logic       I_PWRITE,
	input wire logic [11:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic       O_PREADY,
	// Engine side
	input wire logic       I_TX_END,
	input wire logic       I_RX_END,
	input wire logic       I_TX_REQUEST,
	input wire logic [7:0] I_ERROR_REG,
	input wire logic       O_TX_START,
	input wire logic       O_TX_HOLD,
	input wire logic [2:0] O_STOP_AND_GUARD_CODE,
	input wire logic       O_STOP_BIT_EN,
	input wire logic [2:0] O_EXTRA_GUARD_UNITS,
	input wire logic [2:0] O_RX_BAUD_CODE,
	input wire logic       O_RX_BAUD_VALID,
	input wire logic       O_CONTINUOUS_RECEIVE,
	input wire logic       O_RX_AUTO_STOP,
	input wire logic       O_ERROR_BYTE_VALID,
	input wire logic [7:0] O_ERROR_BYTE
);
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (I_RST);
	logic        origin_rx;
	logic [10:0] wait_value;
	logic        wr_en;
	assign wr_en = I_PSEL && I_PENABLE && I_PWRITE && O_PREADY;
	// Shadow of the wait setup, needed to know which end starts a hold
	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			origin_rx  <= 1'h1;
			wait_value <= 11'h000;
		end else if (wr_en && I_PADDR == 12'hc4) begin
			origin_rx          <= I_PWDATA[7];
			wait_value[10:8]   <= I_PWDATA[5:3];
		end else if (wr_en && I_PADDR == 12'hc8) begin
			wait_value[7:0] <= I_PWDATA[7:0];
		end
	end
	chk_start_gated: assert property (O_TX_START |-> I_TX_REQUEST && !O_TX_HOLD)
		else $error("transmit start while held");
	chk_hold_origin: assert property ((origin_rx ? I_RX_END : I_TX_END) && wait_value != 11'h000
		|-> O_TX_HOLD) else $error("hold missing at wait origin");
	chk_stop_bit: assert property (O_STOP_BIT_EN == (O_STOP_AND_GUARD_CODE != 3'h0))
		else $error("stop bit enable wrong");
	chk_extra_guard: assert property (O_EXTRA_GUARD_UNITS ==
		((O_STOP_AND_GUARD_CODE >= 3'h2) ? O_STOP_AND_GUARD_CODE - 3'h1 : 3'h0))
		else $error("extra guard units wrong");
	chk_stop_write: assert property (wr_en && I_PADDR == 12'hc4
		|=> O_STOP_AND_GUARD_CODE == $past(I_PWDATA[2:0])) else $error("stop code not written");
	chk_baud_valid: assert property (O_RX_BAUD_VALID == (O_RX_BAUD_CODE >= 3'h2))
		else $error("baud valid wrong");
	chk_auto_stop: assert property (O_RX_AUTO_STOP != O_CONTINUOUS_RECEIVE)
		else $error("auto stop not inverse");
	chk_error_byte: assert property (I_RX_END && O_CONTINUOUS_RECEIVE
		|=> O_ERROR_BYTE_VALID && O_ERROR_BYTE == $past(I_ERROR_REG)) else $error("error byte wrong");
	chk_error_only: assert property (O_ERROR_BYTE_VALID
		|-> $past(I_RX_END) && $past(O_CONTINUOUS_RECEIVE)) else $error("spurious error byte");
endmodule : rfsd_frame_timing_properties
bind rfsd_frame_timing rfsd_frame_timing_properties i_props (.I_CORE_CLK(I_CORE_CLK),
	.I_RST(I_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE),
	.I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PREADY(O_PREADY), .I_TX_END(I_TX_END),
	.I_RX_END(I_RX_END), .I_TX_REQUEST(I_TX_REQUEST), .I_ERROR_REG(I_ERROR_REG),
	.O_TX_START(O_TX_START), .O_TX_HOLD(O_TX_HOLD), .O_STOP_AND_GUARD_CODE(O_STOP_AND_GUARD_CODE),
	.O_STOP_BIT_EN(O_STOP_BIT_EN), .O_EXTRA_GUARD_UNITS(O_EXTRA_GUARD_UNITS),
	.O_RX_BAUD_CODE(O_RX_BAUD_CODE), .O_RX_BAUD_VALID(O_RX_BAUD_VALID),
	.O_CONTINUOUS_RECEIVE(O_CONTINUOUS_RECEIVE), .O_RX_AUTO_STOP(O_RX_AUTO_STOP),
	.O_ERROR_BYTE_VALID(O_ERROR_BYTE_VALID), .O_ERROR_BYTE(O_ERROR_BYTE));

// [rfsd_engine_model.sv]
`timescale 1ns/1ps
module rfsd_engine_model #(
	parameter int TICK_GAP = 3
) (
	// Clock and reset
	input  wire logic  i_clk,
	input  wire logic  i_rst,
	// Engine events
	output logic       o_tx_end,
	output logic       o_rx_end,
	output logic       o_tx_request,
	output logic       o_half_bit_tick,
	// Detector levels and error copy
	output logic       o_sof_detect,
	output logic       o_subc_detect,
	output logic [7:0] o_error_reg
);
	int gap_cnt;
	initial begin
		o_tx_end = 1'h0;
		o_rx_end = 1'h0;
		o_tx_request = 1'h0;
		o_sof_detect = 1'h0;
		o_subc_detect = 1'h0;
		o_error_reg = 8'h00;
	end
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			gap_cnt         <= 0;
			o_half_bit_tick <= 1'h0;
		end else begin
			gap_cnt         <= (gap_cnt == TICK_GAP - 1) ? 0 : gap_cnt + 1;
			o_half_bit_tick <= (gap_cnt == TICK_GAP - 1);
		end
	end
	task automatic end_pulse(input logic rx);
		@(posedge i_clk);
		o_rx_end <= rx;
		o_tx_end <= !rx;
		@(posedge i_clk);
		o_rx_end <= 1'h0;
		o_tx_end <= 1'h0;
	endtask : end_pulse
	task automatic set_level(input logic req, input logic sof, input logic subc,
		input logic [7:0] err);
		@(posedge i_clk);
		o_tx_request  <= req;
		o_sof_detect  <= sof;
		o_subc_detect <= subc;
		o_error_reg   <= err;
	endtask : set_level
endmodule : rfsd_engine_model

// [tb_rf_frame_timing_and_sof_detect.sv]
`timescale 1ns/1ps
module tb_rf_frame_timing_and_sof_detect;
	localparam int GAP = 3;
	localparam logic [11:0] A_CTRL = {2'h0, rfsd_pkg::IDX_GUARD_WAIT_CONTROL, 2'h0};
	localparam logic [11:0] A_LOW  = {2'h0, rfsd_pkg::IDX_GUARD_WAIT_LOW, 2'h0};
	localparam logic [11:0] A_FRM  = {2'h0, rfsd_pkg::IDX_FRAME_CONTROL, 2'h0};
	localparam logic [11:0] A_FSD  = {2'h0, rfsd_pkg::IDX_FRAME_START_DETECT, 2'h0};
	localparam logic [11:0] A_RXC  = {2'h0, rfsd_pkg::IDX_RECEIVE_CONTROL, 2'h0};
	localparam logic [11:0] A_IRQ  = {2'h0, rfsd_pkg::IDX_IRQ_STATUS, 2'h0};
	localparam logic [11:0] A_MSK  = {2'h0, rfsd_pkg::IDX_IRQ_MASK, 2'h0};
	localparam logic [11:0] A_ENG  = {2'h0, rfsd_pkg::IDX_ENGINE_STATUS, 2'h0};
	logic clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, e, tx_end, rx_end, tx_req, tick, sof, subc, tx_start, tx_hold;
	logic stop_en, tx_par, rx_par, baud_ok, cont_rx, err_vld, fsi, irq;
	logic [2:0] xgu, baud;
	logic [1:0] trail, lead;
	logic [7:0] err_reg, err_byte, rxcb;
	int err_total = 0, compares = 0;
	always #2.5 clk = !clk;
	rfsd_engine_model #(.TICK_GAP(GAP)) u_eng (.i_clk(clk), .i_rst(rst), .o_tx_end(tx_end),
		.o_rx_end(rx_end), .o_tx_request(tx_req), .o_half_bit_tick(tick),
		.o_sof_detect(sof), .o_subc_detect(subc), .o_error_reg(err_reg));
	rfsd_frame_timing i_dut (.I_CORE_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .I_TX_END(tx_end), .I_RX_END(rx_end),
		.I_TX_REQUEST(tx_req), .I_HALF_BIT_TICK(tick), .I_SOF_DETECT(sof),
		.I_SUBC_DETECT(subc), .I_ERROR_REG(err_reg), .O_TX_START(tx_start), .O_TX_HOLD(tx_hold),
		.O_STOP_AND_GUARD_CODE(), .O_STOP_BIT_EN(stop_en), .O_EXTRA_GUARD_UNITS(xgu),
		.O_TX_PARITY_EN(tx_par), .O_RX_PARITY_EN(rx_par), .O_TRAILING_SYMBOL(trail),
		.O_LEADING_SYMBOL(lead), .O_RX_BAUD_CODE(baud), .O_RX_BAUD_VALID(baud_ok),
		.O_CONTINUOUS_RECEIVE(cont_rx), .O_RX_AUTO_STOP(), .O_ERROR_BYTE_VALID(err_vld),
		.O_ERROR_BYTE(err_byte), .O_RX_CTRL_BITS(rxcb), .O_FRAME_START_INTERRUPT(fsi), .O_IRQ(irq));
	task automatic final_report();
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (n >= 50) begin
			err_total++;
			final_report();
		end
	endtask : apb
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'h0, a, 32'h0);
		chk(r, exp);
		chk(32'(e), 32'h0);
	endtask : rdc
	task automatic guard_run(input logic rx, input int exp_cyc);
		int n;
		n = 1;
		u_eng.end_pulse(rx);
		@(negedge clk);
		while (tx_hold === 1'h1 && n < 5000) begin
			chk(32'(tx_start), 32'h0);
			n++;
			@(negedge clk);
		end
		if (n >= 5000) begin
			err_total++;
			final_report();
		end
		chk(32'(tx_start), 32'h1);
		chk(32'(n >= exp_cyc - 3 && n <= exp_cyc + 3), 32'h1);
	endtask : guard_run
	initial begin
		repeat (60000) @(posedge clk);
		err_total++;
		final_report();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		// Indices between receive control and interrupt status answer with an error
		for (int i = 0; i < 8; i++) begin
			apb(1'h0, A_CTRL + 12'(4 * i), 32'h0);
			chk(r, (i == 0) ? 32'(rfsd_pkg::RST_GUARD_WAIT_CONTROL) : 32'h0);
			chk(32'(e), 32'(i >= 5));
		end
		apb(1'h1, 12'hc0, 32'hff);
		chk(32'(e), 32'h1);
		apb(1'h1, A_FRM, 32'hffffffff);
		rdc(A_FRM, 32'hcf);
		apb(1'h1, A_FSD, 32'hffffffff);
		rdc(A_FSD, 32'h24);
		for (int i = 0; i < 8; i++) begin
			apb(1'h1, A_CTRL, 32'(i));
			apb(1'h1, A_FRM, 32'((i % 4) * 69));
			apb(1'h1, A_RXC, 32'(i));
			@(negedge clk);
			chk(32'(stop_en), 32'(i != 0));
			chk(32'(xgu), (i >= 2) ? 32'(i - 1) : 32'h0);
			chk(32'({trail, lead}), 32'((i % 4) * 5));
			chk(32'({tx_par, rx_par}), 32'(i % 4));
			chk(32'({baud_ok, baud}), 32'((i >= 2) * 8 + i));
			chk(32'(rxcb), 32'(i));
		end
		apb(1'h1, A_CTRL, 32'h0);
		apb(1'h1, A_LOW, 32'h4);
		u_eng.set_level(1'h1, 1'h0, 1'h0, 8'h00);
		guard_run(1'h0, 4 * rfsd_pkg::CARRIER_UNIT_CYC);
		u_eng.end_pulse(1'h1);
		@(negedge clk);
		chk(32'(tx_hold), 32'h0);
		rdc(A_IRQ, 32'h4);
		apb(1'h1, A_MSK, 32'h4);
		@(negedge clk);
		chk(32'(irq), 32'h1);
		apb(1'h1, A_IRQ, 32'h4);
		rdc(A_IRQ, 32'h0);
		chk(32'(irq), 32'h0);
		apb(1'h1, A_LOW, 32'h1);
		apb(1'h1, A_CTRL, 32'hc8);
		guard_run(1'h1, 257 * GAP);
		apb(1'h1, A_RXC, 32'h40);
		u_eng.set_level(1'h0, 1'h0, 1'h0, 8'h5a);
		u_eng.end_pulse(1'h1);
		@(negedge clk);
		chk(32'({cont_rx, err_vld, err_byte}), 32'h35a);
		rdc(A_ENG, 32'h3);
		apb(1'h1, A_FSD, 32'h0);
		u_eng.set_level(1'h0, 1'h1, 1'h0, 8'h00);
		repeat (12) @(negedge clk);
		rdc(A_FSD, 32'h10);
		chk(32'(fsi), 32'h0);
		apb(1'h1, A_FSD, 32'h34);
		@(negedge clk);
		chk(32'(fsi), 32'h1);
		u_eng.set_level(1'h0, 1'h0, 1'h0, 8'h00);
		repeat (12) @(negedge clk);
		rdc(A_FSD, 32'h34);
		apb(1'h1, A_FSD, 32'h24);
		rdc(A_FSD, 32'h24);
		chk(32'(fsi), 32'h0);
		u_eng.set_level(1'h0, 1'h0, 1'h1, 8'h00);
		repeat (12) @(negedge clk);
		rdc(A_FSD, 32'h27);
		chk(32'(fsi), 32'h1);
		u_eng.set_level(1'h0, 1'h0, 1'h0, 8'h00);
		repeat (12) @(negedge clk);
		rdc(A_FSD, 32'h26);
		final_report();
	end
endmodule : tb_rf_frame_timing_and_sof_detect
